// *** cic_mem.sv ***
// cic_mem: cache entry storage, one write port, registered read port, no reset
`timescale 1ns/1ps
module cic_mem #(
    parameter int WIDTH      = 113,
    parameter int DEPTH_LOG2 = 10
) (
    input  wire logic                  clk,
    input  wire logic                  we,
    input  wire logic [DEPTH_LOG2-1:0] waddr,
    input  wire logic [WIDTH-1:0]      wdata,
    input  wire logic                  re,
    input  wire logic [DEPTH_LOG2-1:0] raddr,
    output logic      [WIDTH-1:0]      rdata
);
    logic [WIDTH-1:0] store [2**DEPTH_LOG2];

    // contents survive reset on purpose
    always_ff @(posedge clk) begin
        if (we) begin
            store[waddr] <= wdata;
        end
        if (re) begin
            rdata <= store[raddr];
        end
    end
endmodule

// *** cic_top.sv ***
// cic_pkg and cic_top: instruction cache control, invalidation, error detection and injection
`timescale 1ns/1ps
package cic_pkg;
    // geometry
    localparam int CIC_CACHE_BYTES = 8192;
    localparam int CIC_LINE_BYTES  = 8;
    localparam int CIC_OFS_W       = 3;
    localparam int CIC_IDX_W       = 10;
    localparam int CIC_TAG_W       = 32 - CIC_IDX_W - CIC_OFS_W;
    localparam int CIC_BYTES_LINE  = 8;
    localparam logic [CIC_IDX_W-1:0] CIC_LAST_IDX = 10'h3ff;

    // register byte offsets
    localparam logic [31:0] CIC_OFS_CTRL = 32'h0000_0000;
    localparam logic [31:0] CIC_OFS_CFG0 = 32'h0000_0004;
    localparam logic [31:0] CIC_OFS_CFG1 = 32'h0000_0008;
    localparam logic [31:0] CIC_OFS_STAT = 32'h0000_000c;
    localparam logic [31:0] CIC_OFS_MASK = 32'h0000_0010;

    // control/status field positions
    localparam int CIC_BIT_ENABLE   = 0;
    localparam int CIC_BIT_INV      = 1;
    localparam int CIC_BIT_ABORT    = 2;
    localparam int CIC_BIT_CHECK    = 3;
    localparam int CIC_BIT_EDC      = 4;
    localparam int CIC_BIT_INJ_EN   = 16;
    localparam int CIC_BIT_INJ_TYPE = 17;

    localparam logic [1:0] CIC_INJ_PARITY      = 2'h0;
    localparam logic [1:0] CIC_INJ_DOUBLE      = 2'h1;
    localparam logic [7:0] CIC_INJ_ALL_MASK    = 8'hff;
    localparam logic [7:0] CIC_INJ_DOUBLE_MASK = 8'hc0;

    // configuration words: bit0 split, bit1 instruction cache; size in KB, line bytes
    localparam logic [31:0] CIC_CFG0_VALUE = 32'h0000_0003;
    localparam logic [31:0] CIC_CFG1_VALUE = 32'h0008_0008;

    // event bits of status and mask
    localparam int CIC_NUM_EV      = 5;
    localparam int CIC_EV_INV_DONE = 0;
    localparam int CIC_EV_ABORT    = 1;
    localparam int CIC_EV_TAG_FIX  = 2;
    localparam int CIC_EV_REFILL   = 3;
    localparam int CIC_EV_MCHECK   = 4;

    typedef struct packed {
        logic [1:0] inj_type;
        logic       inj_en;
        logic       edc_en;
        logic       check_en;
        logic       enable;
    } cic_ctrl_t;

    localparam cic_ctrl_t CIC_CTRL_RESET = '{inj_type: 2'h0, inj_en: 1'b0, edc_en: 1'b1,
                                             check_en: 1'b1, enable: 1'b0};

    typedef struct packed {
        logic                 valid;
        logic [CIC_TAG_W-1:0] tag_a;
        logic                 par_a;
        logic [CIC_TAG_W-1:0] tag_b;
        logic                 par_b;
        logic [63:0]          data;
        logic [7:0]           dpar;
    } cic_entry_t;

    localparam int CIC_ENTRY_W = $bits(cic_entry_t);

    typedef enum logic [1:0] {ST_IDLE, ST_INV, ST_CHECK, ST_MEM} cic_state_t;
endpackage

module cic_top import cic_pkg::*; (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    input  wire logic        page_cache_inhibit,
    output logic             fetch_valid,
    output logic [63:0]      fetch_data,
    output logic             fetch_stall,
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [63:0] mem_rdata,
    output logic             irq,
    output logic             machine_check
);
    logic                  ap_valid;
    logic                  ap_write;
    logic [31:0]           ap_addr;
    logic                  ctrl_wr;
    logic                  stat_wr;
    logic                  mask_wr;
    logic [31:0]           rd_word;
    cic_ctrl_t             ctrl;
    logic                  invalidate_request;
    logic                  next_invalidate_request;
    logic                  invalidate_abort_flag;
    logic                  abort_now;
    logic                  inv_done;
    logic [CIC_NUM_EV-1:0] status;
    logic [CIC_NUM_EV-1:0] mask;
    logic [CIC_NUM_EV-1:0] ev_set;
    cic_state_t            state;
    logic [31:0]           req_addr;
    logic                  req_cache;
    logic [CIC_IDX_W-1:0]  inv_idx;
    logic                  fetch_cacheable;
    logic                  take_fetch;
    logic                  mem_we;
    logic [CIC_IDX_W-1:0]  mem_waddr;
    cic_entry_t            mem_wdata;
    logic                  mem_re;
    logic [CIC_ENTRY_W-1:0] mem_rword;
    cic_entry_t            rd;
    logic [CIC_TAG_W-1:0]  req_tag;
    logic [CIC_TAG_W-1:0]  tag_sel;
    logic                  pa_ok;
    logic                  pb_ok;
    logic                  tag_bad;
    logic                  tag_fix;
    logic                  dpar_err;
    logic                  chk_hit;
    logic                  chk_mcheck;
    logic [7:0]            fill_par;
    logic [7:0]            rd_par;
    logic [7:0]            inj_mask;

    // ------------------------------------------------------------
    // ahb-lite slave: zero-wait writes, one wait state on reads
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 32'h0000_0000;
        end else if (hready) begin
            ap_valid <= hsel && htrans[1];
            ap_write <= hwrite;
            ap_addr  <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hreadyout <= 1'b0;
        end else if (!hreadyout) begin
            hreadyout <= 1'b1;
            hrdata    <= rd_word;
        end
    end

    always_comb begin
        ctrl_wr = 1'b0;
        stat_wr = 1'b0;
        mask_wr = 1'b0;
        if (ap_valid && ap_write && hready) begin
            if (ap_addr == CIC_OFS_CTRL) begin
                ctrl_wr = 1'b1;
            end else if (ap_addr == CIC_OFS_STAT) begin
                stat_wr = 1'b1;
            end else if (ap_addr == CIC_OFS_MASK) begin
                mask_wr = 1'b1;
            end
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        if (ap_addr == CIC_OFS_CTRL) begin
            rd_word[CIC_BIT_ENABLE] = ctrl.enable;
            rd_word[CIC_BIT_INV]    = invalidate_request;
            rd_word[CIC_BIT_ABORT]  = invalidate_abort_flag;
            rd_word[CIC_BIT_CHECK]  = ctrl.check_en;
            rd_word[CIC_BIT_EDC]    = ctrl.edc_en;
            rd_word[CIC_BIT_INJ_EN] = ctrl.inj_en;
            rd_word[CIC_BIT_INJ_TYPE +: 2] = ctrl.inj_type;
        end else if (ap_addr == CIC_OFS_CFG0) begin
            rd_word = CIC_CFG0_VALUE;
        end else if (ap_addr == CIC_OFS_CFG1) begin
            rd_word = CIC_CFG1_VALUE;
        end else if (ap_addr == CIC_OFS_STAT) begin
            rd_word[CIC_NUM_EV-1:0] = status;
        end else if (ap_addr == CIC_OFS_MASK) begin
            rd_word[CIC_NUM_EV-1:0] = mask;
        end
    end

    // ------------------------------------------------------------
    // control register and invalidation request
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= CIC_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl.enable   <= hwdata[CIC_BIT_ENABLE];
            ctrl.check_en <= hwdata[CIC_BIT_CHECK];
            ctrl.edc_en   <= hwdata[CIC_BIT_EDC];
            ctrl.inj_en   <= hwdata[CIC_BIT_INJ_EN];
            ctrl.inj_type <= hwdata[CIC_BIT_INJ_TYPE +: 2];
        end
    end

    // writing 0 to the request while a walk runs aborts it
    assign abort_now = ctrl_wr && !hwdata[CIC_BIT_INV] && invalidate_request && !inv_done;

    always_comb begin
        next_invalidate_request = invalidate_request;
        if (inv_done || abort_now) begin
            next_invalidate_request = 1'b0;
        end else if (ctrl_wr && hwdata[CIC_BIT_INV]) begin
            next_invalidate_request = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            invalidate_request    <= 1'b0;
            fetch_stall           <= 1'b0;
            invalidate_abort_flag <= 1'b0;
        end else begin
            invalidate_request <= next_invalidate_request;
            fetch_stall        <= next_invalidate_request;
            if (abort_now) begin
                invalidate_abort_flag <= 1'b1;
            end else if (ctrl_wr && hwdata[CIC_BIT_INV] && !invalidate_request) begin
                invalidate_abort_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
            mask   <= '0;
            irq    <= 1'b0;
        end else begin
            // a new event beats a write-one clear in the same cycle
            status <= (status & ~(stat_wr ? hwdata[CIC_NUM_EV-1:0] : '0)) | ev_set;
            if (mask_wr) begin
                mask <= hwdata[CIC_NUM_EV-1:0];
            end
            irq <= |(status & mask);
        end
    end

    // ------------------------------------------------------------
    // entry storage and parity
    // ------------------------------------------------------------
    cic_mem #(
        .WIDTH      (CIC_ENTRY_W),
        .DEPTH_LOG2 (CIC_IDX_W)
    ) u_mem (
        .clk   (hclk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .re    (mem_re),
        .raddr (fetch_addr[CIC_OFS_W +: CIC_IDX_W]),
        .rdata (mem_rword)
    );

    assign rd = cic_entry_t'(mem_rword);

    for (genvar g = 0; g < CIC_BYTES_LINE; g++) begin : g_par
        assign fill_par[g] = ^mem_rdata[8*g +: 8];
        assign rd_par[g]   = ^rd.data[8*g +: 8];
    end

    always_comb begin
        inj_mask = 8'h00;
        if (ctrl.inj_en && ctrl.inj_type == CIC_INJ_PARITY) begin
            inj_mask = CIC_INJ_ALL_MASK;
        end else if (ctrl.inj_en && ctrl.inj_type == CIC_INJ_DOUBLE) begin
            inj_mask = CIC_INJ_DOUBLE_MASK;
        end
    end

    assign req_tag  = req_addr[31 -: CIC_TAG_W];
    assign pa_ok    = (^rd.tag_a) == rd.par_a;
    assign pb_ok    = (^rd.tag_b) == rd.par_b;
    assign tag_sel  = pa_ok ? rd.tag_a : rd.tag_b;
    assign tag_fix  = pa_ok != pb_ok;
    assign tag_bad  = (!pa_ok && !pb_ok) || (pa_ok && pb_ok && rd.tag_a != rd.tag_b);
    assign dpar_err = rd_par != rd.dpar;

    // instruction side only; lookup skipped when disabled or inhibited
    assign fetch_cacheable = ctrl.enable && !page_cache_inhibit;
    assign take_fetch      = fetch_req && !fetch_valid && !invalidate_request;
    assign mem_re          = state == ST_IDLE && take_fetch && fetch_cacheable;
    assign inv_done        = state == ST_INV && invalidate_request && inv_idx == CIC_LAST_IDX;

    // ------------------------------------------------------------
    // lookup checks, storage writes and events
    // ------------------------------------------------------------
    always_comb begin
        mem_we     = 1'b0;
        mem_waddr  = req_addr[CIC_OFS_W +: CIC_IDX_W];
        mem_wdata  = '0;
        ev_set     = '0;
        chk_hit    = 1'b0;
        chk_mcheck = 1'b0;
        ev_set[CIC_EV_INV_DONE] = inv_done;
        ev_set[CIC_EV_ABORT]    = abort_now;
        case (state)
            ST_INV: begin
                mem_we    = invalidate_request;
                mem_waddr = inv_idx;
            end
            ST_CHECK: begin
                if (!ctrl.check_en) begin
                    chk_hit = rd.valid && rd.tag_a == req_tag;
                end else if (ctrl.edc_en) begin
                    chk_hit = rd.valid && !tag_bad && tag_sel == req_tag && !dpar_err;
                    if (rd.valid && (tag_bad || (tag_sel == req_tag && dpar_err))) begin
                        ev_set[CIC_EV_REFILL] = 1'b1;
                    end
                    if (chk_hit && tag_fix) begin
                        mem_we          = 1'b1;
                        mem_wdata       = rd;
                        mem_wdata.tag_a = tag_sel;
                        mem_wdata.par_a = ^tag_sel;
                        mem_wdata.tag_b = tag_sel;
                        mem_wdata.par_b = ^tag_sel;
                        ev_set[CIC_EV_TAG_FIX] = 1'b1;
                    end
                end else begin
                    if (rd.valid && (!pa_ok || !pb_ok || (rd.tag_a == req_tag && dpar_err)))
                    begin
                        chk_mcheck = 1'b1;
                        ev_set[CIC_EV_MCHECK] = 1'b1;
                    end else begin
                        chk_hit = rd.valid && rd.tag_a == req_tag;
                    end
                end
            end
            ST_MEM: begin
                if (mem_ack && req_cache) begin
                    mem_we          = 1'b1;
                    mem_wdata.valid = 1'b1;
                    mem_wdata.tag_a = req_tag;
                    mem_wdata.par_a = ^req_tag;
                    mem_wdata.tag_b = req_tag;
                    mem_wdata.par_b = ^req_tag;
                    mem_wdata.data  = mem_rdata;
                    mem_wdata.dpar  = fill_par ^ inj_mask;
                end
            end
            default: begin
            end
        endcase
    end

    // ------------------------------------------------------------
    // fetch sequencer
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state         <= ST_IDLE;
            req_addr      <= 32'h0000_0000;
            req_cache     <= 1'b0;
            inv_idx       <= '0;
            fetch_valid   <= 1'b0;
            fetch_data    <= 64'h0000_0000_0000_0000;
            mem_req       <= 1'b0;
            mem_addr      <= 32'h0000_0000;
            machine_check <= 1'b0;
        end else begin
            fetch_valid   <= 1'b0;
            machine_check <= chk_mcheck;
            case (state)
                ST_IDLE: begin
                    if (invalidate_request) begin
                        state   <= ST_INV;
                        inv_idx <= '0;
                    end else if (take_fetch) begin
                        req_addr  <= fetch_addr;
                        req_cache <= fetch_cacheable;
                        if (fetch_cacheable) begin
                            state <= ST_CHECK;
                        end else begin
                            state    <= ST_MEM;
                            mem_req  <= 1'b1;
                            mem_addr <= fetch_addr;
                        end
                    end
                end
                ST_INV: begin
                    if (!invalidate_request || inv_done) begin
                        state <= ST_IDLE;
                    end else begin
                        inv_idx <= inv_idx + 1'b1;
                    end
                end
                ST_CHECK: begin
                    if (chk_hit) begin
                        fetch_valid <= 1'b1;
                        fetch_data  <= rd.data;
                        state       <= ST_IDLE;
                    end else begin
                        state    <= ST_MEM;
                        mem_req  <= 1'b1;
                        mem_addr <= req_addr;
                    end
                end
                ST_MEM: begin
                    if (mem_ack) begin
                        mem_req     <= 1'b0;
                        fetch_valid <= 1'b1;
                        fetch_data  <= mem_rdata;
                        state       <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// *** cic_checker.sv ***
// cic_checker: port-level assertions for cic_top
`timescale 1ns/1ps
module cic_checker import cic_pkg::*; (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic        fetch_valid,
    input wire logic [63:0] fetch_data,
    input wire logic        fetch_stall,
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic [63:0] mem_rdata
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ----------------------------------------
    // helpers: control write data phase, stall length
    // ----------------------------------------
    logic        wr_ctrl;
    logic [10:0] stall_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ctrl   <= 1'h0;
            stall_cnt <= 11'h0;
        end else begin
            wr_ctrl   <= hsel && hready && htrans[1] && hwrite && haddr == CIC_OFS_CTRL;
            stall_cnt <= fetch_stall ? stall_cnt + 11'h1 : 11'h0;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_read_wait;
        hsel && hready && htrans[1] && !hwrite |=> s_rd_wait;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    property p_stall_rise;
        $rose(fetch_stall) |-> $past(wr_ctrl) && $past(hwdata[CIC_BIT_INV]);
    endproperty
    a_stall_rise: assert property (p_stall_rise) else $error("stall without request");
    property p_stall_bound;
        stall_cnt <= 11'h401;
    endproperty
    a_stall_bound: assert property (p_stall_bound) else $error("invalidation too long");
    property p_stall_quiet;
        fetch_stall && $past(fetch_stall, 3) |-> !fetch_valid && !$rose(mem_req);
    endproperty
    a_stall_quiet: assert property (p_stall_quiet) else $error("fetch during stall");
    property p_valid_pulse;
        fetch_valid |=> !fetch_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("fetch valid too long");
    property p_mem_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped");
    property p_mem_done;
        mem_req && mem_ack |=> !mem_req && fetch_valid && fetch_data == $past(mem_rdata);
    endproperty
    a_mem_done: assert property (p_mem_done) else $error("refill data not passed");
    property p_mem_addr;
        $rose(mem_req) |-> mem_addr[31:3] == fetch_addr[31:3];
    endproperty
    a_mem_addr: assert property (p_mem_addr) else $error("memory address wrong");
endmodule

bind cic_top cic_checker u_chk (.*);

// *** cic_mem_model.sv ***
// cic_mem_model: fetch-side memory answering doubleword requests
`timescale 1ns/1ps
module cic_mem_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic             mem_ack,
    output logic [63:0]      mem_rdata
);
    logic [2:0] wait_cnt;
    // data toggles outside the ack cycle so stale reads show
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_ack   <= 1'h0;
            mem_rdata <= 64'h0;
            wait_cnt  <= 3'h0;
        end else if (mem_req && !mem_ack && (!slow || wait_cnt == 3'h4)) begin
            mem_ack   <= 1'h1;
            mem_rdata <= {~mem_addr, mem_addr};
            wait_cnt  <= 3'h0;
        end else begin
            mem_ack   <= 1'h0;
            mem_rdata <= ~mem_rdata;
            wait_cnt  <= mem_req ? wait_cnt + 3'h1 : 3'h0;
        end
    end
endmodule

// *** cic_tb.sv ***
// cic_tb: self-checking testbench for cic_top
`timescale 1ns/1ps
module testbench import cic_pkg::*;;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, slow = 1'h0;
    logic        fetch_req = 1'h0, page_cache_inhibit = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, fetch_addr = 32'h0;
    logic        hready, hreadyout, hresp, fetch_valid, fetch_stall, mem_req, mem_ack;
    logic        irq, machine_check;
    logic [31:0] hrdata, mem_addr, rd;
    logic [63:0] fetch_data, mem_rdata, fd;
    int          n_errors = 0, checks = 0, n_mem = 0, n_mc = 0, n_st = 0, m, c;
    logic [31:0] ofs [5] = '{CIC_OFS_CFG0, CIC_OFS_CFG1, 32'h0000_0020, CIC_OFS_STAT, CIC_OFS_MASK};
    logic [31:0] ofs_e [5] = '{32'h0000_0003, 32'h0008_0008, 32'h0, 32'h0, 32'h0};
    logic [31:0] inj_c [5] = '{32'h0001_0019, 32'h0003_0019, 32'h0001_0019, 32'h0001_0011,
                               32'h0005_0019};
    logic [31:0] use_c [5] = '{32'h0000_0019, 32'h0000_0019, 32'h0000_0009, 32'h0000_0011,
                               32'h0000_0019};
    logic [31:0] st_e [5] = '{32'h0000_0008, 32'h0000_0008, 32'h0000_0010, 32'h0, 32'h0};
    int          mem_e [5] = '{2, 2, 2, 1, 1};

    assign hready = hreadyout;
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        if (mem_req === 1'h1 && mem_ack === 1'h1) n_mem++;
        if (machine_check === 1'h1) n_mc++;
        if (fetch_stall === 1'h1) n_st++;
    end

    cic_top       DUT (.*);
    cic_mem_model u_mem (.*);

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick_rdy();
        int i;
        @(posedge hclk);
        for (i = 0; i < 20 && hreadyout !== 1'h1; i++) @(posedge hclk);
        if (i == 20) begin
            n_errors++;
            wrap_up();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'h1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        tick_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        tick_rdy();
        rd = hrdata;
    endtask
    task automatic fetch(input logic [31:0] a, input logic inh);
        int i;
        fetch_req          <= 1'h1;
        fetch_addr         <= a;
        page_cache_inhibit <= inh;
        for (i = 0; i < 3000 && fetch_valid !== 1'h1; i++) @(posedge hclk);
        fd = fetch_data;
        fetch_req <= 1'h0;
        if (i == 3000) begin
            n_errors++;
            wrap_up();
        end
        chk("fetch_data", {~a, a}, fd);
        @(posedge hclk);
    endtask
    task automatic inv_wait();
        int i;
        for (i = 0; i < 1000; i++) begin
            bus(1'h0, CIC_OFS_CTRL, 32'h0);
            if (rd[CIC_BIT_INV] === 1'h0) break;
        end
        if (i == 1000) begin
            n_errors++;
            wrap_up();
        end
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus(1'h0, CIC_OFS_CTRL, 32'h0);
        chk("ctrl", 32'h0000_0018, rd);
        for (int k = 0; k < 3; k++) bus(1'h1, ofs[k], 32'hffff_ffff);
        for (int k = 0; k < 5; k++) begin
            bus(1'h0, ofs[k], 32'h0);
            chk("reg", ofs_e[k], rd);
        end
        chk("hresp", 1'h0, hresp);
        m = n_mem;
        fetch(32'h0000_0100, 1'h0);
        fetch(32'h0000_0100, 1'h0);
        chk("mem_disabled", 2, n_mem - m);
        bus(1'h1, CIC_OFS_CTRL, 32'h0000_001a);
        m = n_st;
        fork
            fetch(32'h0000_0200, 1'h0);
            inv_wait();
        join
        chk("stall_len", 1025, n_st - m);
        bus(1'h0, CIC_OFS_STAT, 32'h0);
        chk("stat", 32'h0000_0001, rd);
        chk("irq_masked", 1'h0, irq);
        bus(1'h1, CIC_OFS_MASK, 32'h0000_001f);
        bus(1'h0, CIC_OFS_MASK, 32'h0);
        chk("irq", 1'h1, irq);
        bus(1'h1, CIC_OFS_STAT, 32'h0000_001f);
        bus(1'h0, CIC_OFS_STAT, 32'h0);
        chk("stat_clr", 32'h0, rd);
        chk("irq_clr", 1'h0, irq);
        bus(1'h1, CIC_OFS_CTRL, 32'h0000_001a);
        bus(1'h1, CIC_OFS_CTRL, 32'h0000_0018);
        bus(1'h0, CIC_OFS_CTRL, 32'h0);
        chk("ctrl_abort", 32'h0000_001c, rd);
        bus(1'h0, CIC_OFS_STAT, 32'h0);
        chk("stat_abort", 1'h1, rd[CIC_EV_ABORT]);
        bus(1'h1, CIC_OFS_CTRL, 32'h0000_001a);
        inv_wait();
        chk("ctrl_done", 32'h0000_0018, rd);
        bus(1'h1, CIC_OFS_STAT, 32'h0000_001f);
        // barrier time before turning the cache on
        repeat (2) @(posedge hclk);
        bus(1'h1, CIC_OFS_CTRL, 32'h0000_0019);
        m = n_mem;
        fetch(32'h0000_0300, 1'h0);
        fetch(32'h0000_0300, 1'h0);
        fetch(32'h0000_0400, 1'h1);
        fetch(32'h0000_0400, 1'h1);
        chk("mem_enabled", 3, n_mem - m);
        for (int k = 0; k < 5; k++) begin
            m = n_mem;
            c = n_mc;
            slow <= k[0];
            bus(1'h1, CIC_OFS_CTRL, inj_c[k]);
            fetch(32'h0000_1000 + 32'(8 * k), 1'h0);
            bus(1'h1, CIC_OFS_CTRL, use_c[k]);
            fetch(32'h0000_1000 + 32'(8 * k), 1'h0);
            bus(1'h0, CIC_OFS_STAT, 32'h0);
            chk("stat_err", st_e[k], rd);
            chk("mem_err", mem_e[k], n_mem - m);
            chk("mcheck", k == 2, n_mc - c);
            bus(1'h1, CIC_OFS_STAT, 32'h0000_001f);
        end
        // mid-run reset: a cached line must still hit afterwards
        hresetn <= 1'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus(1'h1, CIC_OFS_CTRL, 32'h0000_0019);
        m = n_mem;
        fetch(32'h0000_0300, 1'h0);
        chk("mem_after_reset", 0, n_mem - m);
        wrap_up();
    end
endmodule
